// *** relay_status_indication.sv ***
`timescale 1ns/100ps
// Contract
// - Drive green ready, yellow start, red trip indicators
// - Show text on internal fault or alarm
// - Display priority: fault, then trip/breaker failure, start
// - Restart first; persistent fault blinks, asserts output
// - Nothing overrides the shown fault indication
// - Ignore fault clear while ready indicator blinks
// - Fault gone: stop blink, release output, keep text
// - Fault code holds the latest detected fault type
// - Test mode: show input, drive one signal
// - Tested routed signal energises contact, raises event
module relay_status_indication
    import relay_status_pkg::*;
#(
    // Half blink period in cycles, shorten for simulation
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
    // Restarts tried before the fault is permanent
    parameter logic [RETRY_W-1:0] RETRIES = RESTART_RETRIES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [STAGE_N-1:0] stage_signals_i, // Stage outputs
    input wire logic stage_start_i, // Any stage started
    input wire logic stage_trip_i, // Any stage tripped
    input wire logic breaker_failure_indication_i, // Breaker failure
    input wire logic fault_detect_i, // Self-supervision fault present
    input wire logic [CODE_W-1:0] fault_type_i, // Type of that fault
    input wire logic restart_done_i, // Restart has completed
    input wire logic clear_i, // Request to clear indications
    input wire logic binary_input_i, // External binary input
    input wire logic io_test_mode_i, // I/O test mode active
    input wire logic [SEL_W-1:0] io_test_select_i, // Signal under test
    // Routing mask: bit k*8+s links stage s to contact k
    input wire logic [CONTACT_N*STAGE_N-1:0] output_routing_switches_i,
    output logic ready_led_o,
    output logic start_led_o,
    output logic trip_led_o,
    output msg_e display_msg_o,
    output logic internal_fault_output_o,
    output logic [CODE_W-1:0] fault_code_o,
    output logic restart_req_o,
    output logic binary_input_state_o,
    output logic power_output_contact_a_o,
    output logic power_output_contact_b_o,
    output logic signal_output_contact_a_o,
    output logic signal_output_contact_b_o,
    output logic [CODE_W-1:0] event_code_o,
    output logic event_valid_o
);

    // Link to the display selector
    indication_if ind ();

    // All state of the supervisor
    typedef struct packed {
        sup_e st; // Supervision sequence state
        logic [RETRY_W-1:0] tries; // Restarts done so far
        logic [CODE_W-1:0] code; // Latest fault code
        logic text; // Fault text latched
        logic start_lat; // Start indication latched
        logic trip_lat; // Trip indication latched
        logic internal_fault_output; // Fault output
        logic restart; // Restart request pulse
        logic fault_prev; // Fault input one cycle ago
        logic bin; // Binary input shown in test
        logic [CONTACT_N-1:0] cont; // Output contacts
        logic [CODE_W-1:0] ev_code; // Last event code
        logic ev_valid; // Event pulse
    } sup_s;

    sup_s s; // Current state
    sup_s next_s; // Next state

    // One-hot decode of the test selector, bit 8 is the fault output
    function automatic logic [STAGE_N:0] test_vector(
        input logic [SEL_W-1:0] sel
    );
        logic [STAGE_N:0] v;
        v = '0;
        if (sel <= TEST_SEL_FAULT) begin
            v[sel] = 1'b1;
        end
        return v;
    endfunction : test_vector

    logic [STAGE_N:0] tvec; // Test selection
    logic [STAGE_N-1:0] drive_vec; // Stage signals seen by contacts
    logic [CONTACT_N-1:0] cont_now; // Contacts before the register

    // Only one signal at a time can be live in test mode
    assign tvec = test_vector(io_test_select_i);
    assign drive_vec = io_test_mode_i ? tvec[STAGE_N-1:0] :
        stage_signals_i;

    // Each contact follows any routed stage signal
    for (genvar k = 0; k < CONTACT_N; k++) begin : g_contact
        assign cont_now[k] = |(drive_vec &
            output_routing_switches_i[k*STAGE_N +: STAGE_N]);
    end

    // Next state logic
    always_comb begin
        logic fault_rise;
        logic [CONTACT_N-1:0] rise;
        fault_rise = 1'b0;
        rise = '0;
        next_s = s;
        next_s.restart = 1'b0;
        next_s.ev_valid = 1'b0;
        next_s.fault_prev = fault_detect_i;
        fault_rise = fault_detect_i & ~s.fault_prev;
        // A new fault always replaces the stored code
        if (fault_rise) begin
            next_s.code = fault_type_i;
        end
        case (s.st)
            SUP_IDLE, SUP_LATCHED: begin
                // Try a restart before calling it permanent
                if (fault_detect_i) begin
                    next_s.st = SUP_RESTART;
                    next_s.tries = '0;
                end
            end
            SUP_RESTART: begin
                next_s.restart = 1'b1;
                next_s.tries = s.tries + 1'b1;
                next_s.st = SUP_WAIT;
            end
            SUP_WAIT: begin
                if (restart_done_i) begin
                    if (!fault_detect_i) begin
                        // Restart cured it; keep any earlier text
                        next_s.st = s.text ? SUP_LATCHED : SUP_IDLE;
                    end else if (s.tries >= RETRIES) begin
                        next_s.st = SUP_PERMANENT;
                    end else begin
                        next_s.st = SUP_RESTART;
                    end
                end
            end
            SUP_PERMANENT: begin
                // Output and text while the fault persists
                next_s.text = 1'b1;
                if (!fault_detect_i) begin
                    next_s.st = SUP_LATCHED;
                end
            end
            default: begin
                next_s.st = SUP_IDLE;
            end
        endcase
        // Fault output asserted only in the permanent state; in test mode the selector drives it instead
        next_s.internal_fault_output = (next_s.st == SUP_PERMANENT);
        if (io_test_mode_i) begin
            next_s.internal_fault_output = tvec[STAGE_N];
        end
        // Alarm latches, set wins over clear in the same cycle
        if (clear_i) begin
            next_s.start_lat = 1'b0;
            next_s.trip_lat = 1'b0;
            // A blinking fault cannot be cleared
            if (s.st != SUP_PERMANENT && next_s.st != SUP_PERMANENT) begin
                next_s.text = 1'b0;
            end
        end
        if (stage_start_i) begin
            next_s.start_lat = 1'b1;
        end
        if (stage_trip_i | breaker_failure_indication_i) begin
            next_s.trip_lat = 1'b1;
        end
        if (next_s.st == SUP_PERMANENT) begin
            next_s.text = 1'b1;
        end
        // Contacts and one event per cycle, for the lowest newly closed contact
        next_s.cont = cont_now;
        rise = cont_now & ~s.cont;
        for (int k = CONTACT_N - 1; k >= 0; k--) begin
            if (rise[k]) begin
                next_s.ev_valid = 1'b1;
                next_s.ev_code = EVENT_BASE + CODE_W'(k);
            end
        end
        // Binary input is shown only in test mode
        next_s.bin = io_test_mode_i & binary_input_i;
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '{st: SUP_IDLE, tries: '0, code: FAULT_CODE_RST,
                   text: 1'b0, start_lat: 1'b0, trip_lat: 1'b0,
                   internal_fault_output: 1'b0, restart: 1'b0, fault_prev: 1'b0,
                   bin: 1'b0, cont: '0, ev_code: '0, ev_valid: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Feed the selector
    assign ind.fault_text = s.text;
    assign ind.blinking = (s.st == SUP_PERMANENT);
    assign ind.trip_lat = s.trip_lat;
    assign ind.start_lat = s.start_lat;

    // Blink divider and priority selection
    display_selector #(
        .BLINK_HALF(BLINK_HALF)
    ) u_selector (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ind(ind.selector)
    );

    // Ready lit when healthy, dark during restarts, blinks on fault
    assign ready_led_o = (s.st == SUP_PERMANENT) ? ~ind.blink :
        (s.st == SUP_IDLE || s.st == SUP_LATCHED);
    assign start_led_o = s.start_lat;
    assign trip_led_o = s.trip_lat;
    assign display_msg_o = ind.msg;
    assign internal_fault_output_o = s.internal_fault_output;
    assign fault_code_o = s.code;
    assign restart_req_o = s.restart;
    assign binary_input_state_o = s.bin;
    assign power_output_contact_a_o = s.cont[0];
    assign power_output_contact_b_o = s.cont[1];
    assign signal_output_contact_a_o = s.cont[2];
    assign signal_output_contact_b_o = s.cont[3];
    assign event_code_o = s.ev_code;
    assign event_valid_o = s.ev_valid;

endmodule : relay_status_indication

// *** relay_status_pkg.sv ***
package relay_status_pkg;

    // System clock rate in hertz
    localparam int unsigned CLK_HZ = 40_000_000;
    // Half period of the ready indicator blink, in milliseconds
    localparam int unsigned BLINK_HALF_MS = 500;
    // Half blink period in clock cycles, rounded down
    localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
    // Width of the blink cycle counter
    localparam int unsigned BLINK_CNT_W = 25;

    // Restarts tried before a fault is taken as permanent
    localparam int unsigned RETRY_W = 2;
    localparam logic [RETRY_W-1:0] RESTART_RETRIES = 2'h3;

    // Widths of stage vector, fault code, event code
    localparam int unsigned STAGE_N = 8;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned CONTACT_N = 4;
    localparam int unsigned SEL_W = 4;

    // Reset value of the fault code
    localparam logic [CODE_W-1:0] FAULT_CODE_RST = 8'h00;
    // Event code of contact k is EVENT_BASE + k
    localparam logic [CODE_W-1:0] EVENT_BASE = 8'h10;
    // Test selector value that picks the fault output
    localparam logic [SEL_W-1:0] TEST_SEL_FAULT = 4'h8;

    // Message shown on the display
    typedef enum logic [1:0] {
        MSG_NONE,
        MSG_FAULT,
        MSG_TRIP,
        MSG_START
    } msg_e;

    // Self-supervision sequence
    typedef enum logic [2:0] {
        SUP_IDLE,
        SUP_RESTART,
        SUP_WAIT,
        SUP_PERMANENT,
        SUP_LATCHED
    } sup_e;

endpackage : relay_status_pkg

// *** indication_if.sv ***
`timescale 1ns/100ps
// Carries indication state between the supervisor and the display selector
interface indication_if;
    import relay_status_pkg::*;
    logic fault_text; // Fault text latched on the display
    logic blinking; // Permanent fault present
    logic trip_lat; // Trip or breaker failure latched
    logic start_lat; // Start latched
    logic blink; // Blink phase
    msg_e msg; // Selected display message
    modport supervisor (
        output fault_text, blinking, trip_lat, start_lat,
        input blink, msg
    );
    modport selector (
        input fault_text, blinking, trip_lat, start_lat,
        output blink, msg
    );
endinterface : indication_if

// *** display_selector.sv ***
`timescale 1ns/100ps
// Blink divider and display message priority
module display_selector
    import relay_status_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    indication_if.selector ind
);

    // All state of the selector
    typedef struct packed {
        logic [BLINK_CNT_W-1:0] cnt; // Cycles into this blink phase
        logic blink; // Current blink phase
        msg_e msg; // Registered display message
    } sel_s;

    sel_s s; // Current state
    sel_s next_s; // Next state

    // Counter end value at the counter width
    localparam logic [BLINK_CNT_W-1:0] CNT_END =
        BLINK_CNT_W'(BLINK_HALF - 1);

    // Next state logic
    always_comb begin
        next_s = s;
        // Blink runs only while a permanent fault is present
        if (ind.blinking) begin
            if (s.cnt == CNT_END) begin
                next_s.cnt = '0;
                next_s.blink = ~s.blink;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end else begin
            // Restart phase so each blink begins lit
            next_s.cnt = '0;
            next_s.blink = 1'b0;
        end
        // Fault text first, then trip, then start
        if (ind.fault_text) begin
            next_s.msg = MSG_FAULT;
        end else if (ind.trip_lat) begin
            next_s.msg = MSG_TRIP;
        end else if (ind.start_lat) begin
            next_s.msg = MSG_START;
        end else begin
            next_s.msg = MSG_NONE;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '{cnt: '0, blink: 1'b0, msg: MSG_NONE};
        end else begin
            s <= next_s;
        end
    end

    assign ind.blink = s.blink;
    assign ind.msg = s.msg;

endmodule : display_selector

// *** panel_model.sv ***
`timescale 1ns/100ps
// Front panel and contact side: logs each event the block raises
module panel_model
    import relay_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic event_valid_i,
    input wire logic [CODE_W-1:0] event_code_i,
    output logic [CODE_W-1:0] last_event_o,
    output int event_count_o
);
    // Empty log until the first event
    initial begin
        last_event_o = 8'h00;
        event_count_o = 0;
    end
    // Takes the code in the single cycle that valid stands
    always @(posedge clk_i) begin
        if (event_valid_i) begin
            last_event_o <= event_code_i;
            event_count_o <= event_count_o + 1;
        end
    end
endmodule : panel_model

// *** relay_status_props.sv ***
`timescale 1ns/100ps
// Port checker for the status and supervision block
module relay_status_props
    import relay_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic stage_start_i,
    input wire logic fault_detect_i,
    input wire logic [CODE_W-1:0] fault_type_i,
    input wire logic restart_done_i,
    input wire logic clear_i,
    input wire logic binary_input_i,
    input wire logic io_test_mode_i,
    input wire logic [SEL_W-1:0] io_test_select_i,
    input wire logic [CONTACT_N*STAGE_N-1:0] output_routing_switches_i,
    input wire logic ready_led_o,
    input wire logic start_led_o,
    input wire logic trip_led_o,
    input wire msg_e display_msg_o,
    input wire logic internal_fault_output_o,
    input wire logic [CODE_W-1:0] fault_code_o,
    input wire logic restart_req_o,
    input wire logic binary_input_state_o,
    input wire logic power_output_contact_a_o,
    input wire logic [CODE_W-1:0] event_code_o,
    input wire logic event_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Permanent fault signalled by supervision, not by the test mode
    sequence perm_seen;
        internal_fault_output_o && !io_test_mode_i;
    endsequence
    // After release: output low, lamp steady, text kept
    sequence settled;
        (!internal_fault_output_o && ready_led_o &&
            display_msg_o == MSG_FAULT) [*4];
    endsequence
    restart_pulse_a: assert property (
        restart_req_o |=> !restart_req_o)
        else $error("restart request longer than one cycle");
    fault_cause_a: assert property (
        $rose(internal_fault_output_o) && !io_test_mode_i
        |-> $past(restart_done_i) && $past(fault_detect_i))
        else $error("fault output raised without a failed restart");
    fault_text_a: assert property (
        perm_seen and $rose(internal_fault_output_o)
        |=> display_msg_o == MSG_FAULT) else $error("fault text missing");
    fault_first_a: assert property (
        perm_seen and display_msg_o == MSG_FAULT
        |=> display_msg_o == MSG_FAULT) else $error("fault text replaced");
    clear_ignored_a: assert property (
        perm_seen and clear_i
        |=> display_msg_o == MSG_FAULT [*2]) else $error("clear took effect");
    fault_release_a: assert property (
        $fell(fault_detect_i) ##0 perm_seen
        |=> settled) else $error("fault release wrong");
    code_latest_a: assert property (
        $rose(fault_detect_i)
        |=> fault_code_o == $past(fault_type_i)) else $error("stale fault code");
    trip_rank_a: assert property (
        trip_led_o && !internal_fault_output_o &&
        display_msg_o != MSG_FAULT |=> display_msg_o == MSG_TRIP)
        else $error("trip message not shown");
    start_rank_a: assert property (
        $rose(start_led_o) && !trip_led_o &&
        display_msg_o == MSG_NONE |=> display_msg_o == MSG_START)
        else $error("start message not shown");
    start_lamp_a: assert property (
        stage_start_i |=> start_led_o)
        else $error("start lamp not lit");
    input_view_a: assert property (
        binary_input_state_o ==
        ($past(io_test_mode_i) && $past(binary_input_i)))
        else $error("binary input state wrong");
    test_route_a: assert property (
        io_test_mode_i && io_test_select_i < TEST_SEL_FAULT &&
        output_routing_switches_i[io_test_select_i]
        |=> power_output_contact_a_o) else $error("routed contact idle");
    event_raise_a: assert property (
        $rose(power_output_contact_a_o)
        |-> event_valid_o && event_code_o == EVENT_BASE)
        else $error("contact event missing");
endmodule : relay_status_props
bind relay_status_indication relay_status_props relay_status_props_inst (
    .clk_i, .rst_b_i, .stage_start_i, .fault_detect_i, .fault_type_i,
    .restart_done_i, .clear_i, .binary_input_i, .io_test_mode_i,
    .io_test_select_i, .output_routing_switches_i, .ready_led_o,
    .start_led_o, .trip_led_o, .display_msg_o, .internal_fault_output_o,
    .fault_code_o, .restart_req_o, .binary_input_state_o,
    .power_output_contact_a_o, .event_code_o, .event_valid_o);

// *** relay_status_indication_tb.sv ***
`timescale 1ns/100ps
// Self-checking bench for the status and supervision block
module relay_status_indication_tb;
    import relay_status_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] stage_signals_i = 8'h00;
    logic stage_start_i = 1'b0;
    logic stage_trip_i = 1'b0;
    logic breaker_failure_indication_i = 1'b0;
    logic fault_detect_i = 1'b0;
    logic [7:0] fault_type_i = 8'h00;
    logic restart_done_i = 1'b0;
    logic clear_i = 1'b0;
    logic binary_input_i = 1'b0;
    logic io_test_mode_i = 1'b0;
    logic [3:0] io_test_select_i = 4'h9;
    // Stage s drives contact s mod 4
    logic [31:0] output_routing_switches_i = 32'h88442211;
    logic ready_led_o, start_led_o, trip_led_o, internal_fault_output_o;
    logic restart_req_o, binary_input_state_o, event_valid_o;
    logic power_output_contact_a_o, power_output_contact_b_o;
    logic signal_output_contact_a_o, signal_output_contact_b_o;
    logic [7:0] fault_code_o, event_code_o, last_event;
    msg_e display_msg_o;
    int event_count, mismatches = 0, checked = 0;
    logic [3:0] contacts;
    logic [7:0] contact_byte; // Contacts widened for the compare task
    logic [7:0] fault_out; // Fault output widened for the compare task
    assign contact_byte = {4'h0, contacts};
    assign fault_out = {7'h0, internal_fault_output_o};
    assign contacts = {signal_output_contact_b_o, signal_output_contact_a_o,
        power_output_contact_b_o, power_output_contact_a_o};
    // Short blink so a few toggles fit in a scenario
    relay_status_indication #(.BLINK_HALF(4)) relay_status_indication_inst (
        .clk_i, .rst_b_i, .stage_signals_i, .stage_start_i, .stage_trip_i,
        .breaker_failure_indication_i, .fault_detect_i, .fault_type_i,
        .restart_done_i, .clear_i, .binary_input_i, .io_test_mode_i,
        .io_test_select_i, .output_routing_switches_i, .ready_led_o,
        .start_led_o, .trip_led_o, .display_msg_o, .internal_fault_output_o,
        .fault_code_o, .restart_req_o, .binary_input_state_o,
        .power_output_contact_a_o, .power_output_contact_b_o,
        .signal_output_contact_a_o, .signal_output_contact_b_o,
        .event_code_o, .event_valid_o);
    panel_model panel_model_inst (.clk_i, .event_valid_i(event_valid_o),
        .event_code_i(event_code_o), .last_event_o(last_event),
        .event_count_o(event_count));
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Plays the restart logic: waits for a request, then reports done
    task automatic serve_restart();
        int n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (restart_req_o !== 1'b1 && n < 20);
        chk("restart_req_o", 8'h01, {7'h0, restart_req_o});
        @(posedge clk_i);
        restart_done_i <= 1'b1;
        @(posedge clk_i);
        restart_done_i <= 1'b0;
    endtask : serve_restart
    task automatic test_alarms();
        tick(1);
        stage_start_i <= 1'b1;
        tick(1);
        stage_start_i <= 1'b0;
        breaker_failure_indication_i <= 1'b1;
        #1 chk("start_led_o", 8'h01, {7'h0, start_led_o});
        tick(1);
        breaker_failure_indication_i <= 1'b0;
        #1 chk("trip_led_o", 8'h01, {7'h0, trip_led_o});
        tick(1);
        clear_i <= 1'b1;
        #1 chk("display", MSG_TRIP, display_msg_o);
        tick(2);
        clear_i <= 1'b0;
        #1 chk("display", MSG_NONE, display_msg_o);
        chk("start_led_o", 8'h00, {7'h0, start_led_o});
        $display("test alarms done");
    endtask : test_alarms
    task automatic test_fault();
        int flips = 0;
        logic prev;
        tick(1);
        fault_type_i <= 8'h5A;
        fault_detect_i <= 1'b1;
        repeat (3) serve_restart();
        #1 chk("fault output", 8'h01, fault_out);
        chk("fault_code_o", 8'h5A, fault_code_o);
        tick(1);
        stage_trip_i <= 1'b1;
        clear_i <= 1'b1;
        #1 chk("display", MSG_FAULT, display_msg_o);
        prev = ready_led_o;
        repeat (16) begin
            @(posedge clk_i);
            #1;
            flips += int'(ready_led_o !== prev);
            prev = ready_led_o;
        end
        chk("ready flips", 8'h04, 8'(flips));
        chk("display", MSG_FAULT, display_msg_o);
        tick(1);
        {stage_trip_i, clear_i, fault_detect_i} <= 3'h0;
        tick(1);
        #1 chk("fault output", 8'h00, fault_out);
        tick(5);
        #1 chk("ready_led_o", 8'h01, {7'h0, ready_led_o});
        chk("display", MSG_FAULT, display_msg_o);
        tick(1);
        fault_type_i <= 8'hA5;
        fault_detect_i <= 1'b1;
        tick(1);
        fault_detect_i <= 1'b0;
        #1 chk("fault_code_o", 8'hA5, fault_code_o);
        serve_restart();
        clear_i <= 1'b1;
        tick(1);
        clear_i <= 1'b0;
        tick(1);
        #1 chk("display", MSG_NONE, display_msg_o);
        $display("test fault done");
    endtask : test_fault
    task automatic test_io();
        logic [7:0] exp_c;
        logic [7:0] exp_e;
        tick(1);
        stage_signals_i <= 8'h02;
        tick(2);
        #1 chk("contacts", 8'h02, {4'h0, contacts});
        chk("last event", 8'h11, last_event);
        tick(1);
        {stage_signals_i, io_test_mode_i, binary_input_i} <= 10'h003;
        for (int s = 0; s < 9; s++) begin
            tick(1);
            io_test_select_i <= 4'(s);
            tick(2);
            exp_c = (s < 8) ? 8'(1 << (s % 4)) : 8'h00;
            exp_e = EVENT_BASE + 8'(s % 4);
            #1 chk("contacts", exp_c, contact_byte);
            if (s < 8) begin
                chk("last event", exp_e, last_event);
            end else begin
                chk("test fault", 8'h01, fault_out);
            end
            tick(1);
            io_test_select_i <= 4'h9;
        end
        #1 chk("input state", 8'h01, {7'h0, binary_input_state_o});
        chk("event count", 8'h09, 8'(event_count));
        tick(1);
        {io_test_mode_i, binary_input_i} <= 2'h0;
        $display("test io done");
    endtask : test_io
    task automatic finish_test();
        $display("counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // Whole run is about a hundred cycles; allow ample margin
    initial begin
        #(25 * 3000);
        mismatches++;
        $display("BAD watchdog expected end seen timeout");
        finish_test();
    end
    initial begin
        tick(4);
        rst_b_i <= 1'b1;
        #1 chk("ready_led_o", 8'h01, {7'h0, ready_led_o});
        chk("fault_code_o", FAULT_CODE_RST, fault_code_o);
        test_alarms();
        test_fault();
        test_io();
        finish_test();
    end
endmodule : relay_status_indication_tb
